/* File: cart_regs.svh */
// Timing counts, field widths and code values for the charge converter readout.
`ifndef CART_REGS_SVH
`define CART_REGS_SVH
// ----------------------------------------------------------------------------
// Slow clock and timing
// ----------------------------------------------------------------------------
`define CART_CLK_PERIOD_NS      20
`define CART_SLOW_DIV           6
`define CART_BOUNDARY_CYCLES    4794
`define CART_MRAZ_SLOW_CYCLES   64
`define CART_READY_SLOW_CYCLES  40
`define CART_SECOND_SLOW_CYCLES 20
`define CART_QUIET_NS           10000
`define CART_QUIET_CYCLES       ((`CART_QUIET_NS + `CART_CLK_PERIOD_NS - 1) / `CART_CLK_PERIOD_NS)
`define CART_IDLE_HIGH_NS       2000
`define CART_IDLE_HIGH_CYCLES   ((`CART_IDLE_HIGH_NS + `CART_CLK_PERIOD_NS - 1) / `CART_CLK_PERIOD_NS)
// ----------------------------------------------------------------------------
// Result format
// ----------------------------------------------------------------------------
`define CART_RESULT_W           20
`define CART_FRAME_BITS         40
`define CART_CODE_FULL          20'hfffff
`define CART_CODE_ZERO          20'h01000
`define CART_CODE_CLIP          20'h00000
`define CART_SHIFT_HALF         4
`endif

/* File: cart_pkg.sv */
// Types shared by both ends of the charge converter readout link.
package cart_pkg;
  typedef logic [19:0] cart_result_t;
  typedef enum logic [1:0] {CART_GAPLESS, CART_GAPPED} cart_mode_t;
  typedef enum logic [2:0] {CART_C_IDLE, CART_C_WAIT, CART_C_LOW, CART_C_HIGH,
                            CART_C_DONE} cart_ctl_state_t;
endpackage

/* File: cart_link_if.sv */
// Interface joining the converter end and the readout controller end.
interface cart_link_if;
  logic integration_side_select;
  logic result_ready_n;
  logic transmit_enable_n;
  logic serial_shift_clock;
  logic serial_out;
  logic serial_out_oe;
  logic chain_in;
  modport device (input integration_side_select, input transmit_enable_n,
                  input serial_shift_clock, input chain_in,
                  output result_ready_n, output serial_out, output serial_out_oe);
  modport host (output integration_side_select, output transmit_enable_n,
                output serial_shift_clock, input result_ready_n,
                input serial_out, input serial_out_oe);
endinterface

/* File: cart_slow_div.sv */
// Divide-by-six slow clock generator with gating and realignment.
module cart_slow_div
  import cart_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Control
  input  wire logic run,
  input  wire logic realign,
  // Outputs
  output logic      slow_tick,
  output logic      slow_level
);
  `include "cart_regs.svh"
  logic [2:0] cnt_q;

  // Counts master clocks; realign restarts phase so the first edge is fixed.
  always_ff @(posedge core_clk) begin
    if (rst || realign) begin
      cnt_q <= 3'h0;
    end else if (run) begin
      cnt_q <= (cnt_q == 3'(`CART_SLOW_DIV - 1)) ? 3'h0 : cnt_q + 3'h1;
    end
  end

  // One tick per slow period and a square level of 120 ns period at 50 MHz.
  assign slow_tick  = run && (cnt_q == 3'(`CART_SLOW_DIV - 1));
  assign slow_level = (cnt_q >= 3'(`CART_SLOW_DIV / 2));
endmodule // cart_slow_div

/* File: cart_device.sv */
// Converter end: slow clock, data-ready logic and serial readout chain.
//
// Summary of operation
// RULE1: slow clock is master clock divided by six.
// RULE2: controller toggles side select on master clock.
// RULE3: gapless mode stops slow clock after sequence.
// RULE4: long gapless integrations see equal slow edges.
// RULE5: gapped mode keeps slow clock running always.
// RULE6: controller picks periods in half-slow-period steps.
// RULE7: long periods realign slow clock to toggle.
// RULE8: short periods never realign; ready jitters three.
// RULE9: second gapped ready timed from first ready.
// RULE10: controller polls ready or waits maximum delay.
// RULE11: latest result is readable at ready fall.
// RULE12: transmit enable fall starts shifting with clock.
// RULE13: controller keeps shift clock quiet near toggles; the code holds back only rises, and a fall already due still happens.
// RULE14: results are 20-bit straight binary codes.
// RULE15: zero input maps to offset code, clips low.
// RULE16: chain input passes through serial output.
// RULE17: chain input captured on shift clock rise.
// RULE18: serial output changes after shift clock fall.
// RULE19: ready falls on clock edge, rises on enable.
// RULE20: serial output released while enable high.
// RULE21: controller holds enable high before ready falls.
// RULE22: forty bits per device per readout.
// RULE23: each result shifted most significant bit first.
// RULE24: after own bits, chain bits follow delayed.
module cart_device
  import cart_pkg::*;
(
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst,
  // Link to controller
  cart_link_if.device link,
  // Converter core results
  input  wire logic   [19:0] result_a,
  input  wire logic   [19:0] result_b,
  input  wire logic          result_in_range_low,
  // Status
  output logic        gapped_mode,
  output logic        slow_running
);
  `include "cart_regs.svh"

  // --------------------------------------------------------------------------
  // Side select tracking and integration length
  // --------------------------------------------------------------------------
  logic        side_q;
  logic        toggle;
  logic [12:0] int_len_q;
  logic        long_q;

  assign toggle = link.integration_side_select != side_q;

  // Measures each integration in master clocks to pick the mode.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      side_q    <= 1'b0;
      int_len_q <= 13'h0;
      long_q    <= 1'b0;
    end else begin
      side_q <= link.integration_side_select;
      if (toggle) begin
        int_len_q <= 13'h0;
        long_q    <= (int_len_q >= 13'(`CART_BOUNDARY_CYCLES - 1));
      end else if (int_len_q != 13'h1fff) begin
        int_len_q <= int_len_q + 13'h1;
      end
    end
  end

  assign gapped_mode = !long_q;

  // --------------------------------------------------------------------------
  // Slow clock with gating
  // --------------------------------------------------------------------------
  logic       slow_tick;
  logic       run_q;
  logic [6:0] seq_q;
  logic       realign;

  // Gapless: restart with fixed phase on each toggle. Gapped: never realign.
  assign realign = toggle && long_q;  // see RULE7 see RULE8

  cart_slow_div u_div (
    .core_clk   (core_clk),
    .rst        (rst),
    .run        (run_q),
    .realign    (realign),
    .slow_tick  (slow_tick),
    .slow_level ()
  );  // see RULE1

  // Runs the slow clock for the sequence, stopping it afterwards in gapless mode.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_q <= 1'b1;
      seq_q <= 7'h0;
    end else if (toggle) begin
      run_q <= 1'b1;                                        // see RULE3
      seq_q <= 7'h0;
    end else if (slow_tick && seq_q != 7'(`CART_MRAZ_SLOW_CYCLES)) begin
      seq_q <= seq_q + 7'h1;
    end else if (seq_q == 7'(`CART_MRAZ_SLOW_CYCLES) && long_q) begin
      run_q <= 1'b0;                                        // see RULE3 see RULE4
    end else if (!long_q) begin
      run_q <= 1'b1;                                        // see RULE5
    end
  end

  assign slow_running = run_q;

  // --------------------------------------------------------------------------
  // Data-ready generation
  // --------------------------------------------------------------------------
  logic       ready_n_q;
  logic       second_pend_q;
  logic [5:0] second_cnt_q;
  logic       fire;
  logic       xmit_n_q;
  logic       xmit_fall;

  assign xmit_fall = xmit_n_q && !link.transmit_enable_n;
  assign fire = slow_tick && seq_q == 7'(`CART_READY_SLOW_CYCLES - 1);

  // Ready falls on a clock edge from a slow tick; first transmit enable low lifts it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ready_n_q     <= 1'b1;
      second_pend_q <= 1'b0;
      second_cnt_q  <= 6'h0;
      xmit_n_q      <= 1'b1;
    end else begin
      xmit_n_q <= link.transmit_enable_n;
      // Enable fall lifts the flag; a ready set below in the same cycle wins.
      if (xmit_fall) begin
        ready_n_q <= 1'b1;                                 // see RULE19
      end
      if (fire) begin
        ready_n_q     <= 1'b0;                             // see RULE19
        second_pend_q <= !long_q;
        second_cnt_q  <= 6'h0;
      end else if (second_pend_q && slow_tick) begin
        // Second gapped ready is counted in slow ticks from the first.
        if (second_cnt_q == 6'(`CART_SECOND_SLOW_CYCLES - 1)) begin
          ready_n_q     <= 1'b0;                           // see RULE9
          second_pend_q <= 1'b0;
        end else begin
          second_cnt_q <= second_cnt_q + 6'h1;
        end
      end
    end
  end

  assign link.result_ready_n = ready_n_q;

  // --------------------------------------------------------------------------
  // Result latch and code clipping
  // --------------------------------------------------------------------------
  logic [39:0] frame_q;
  logic [19:0] code_a;
  logic [19:0] code_b;

  // Below about minus 0.4 percent the offset code clips to zero.
  assign code_a = result_in_range_low ? `CART_CODE_CLIP : result_a;  // see RULE14 see RULE15
  assign code_b = result_in_range_low ? `CART_CODE_CLIP : result_b;  // see RULE15

  // --------------------------------------------------------------------------
  // Serial shifter on the sampled shift clock
  // --------------------------------------------------------------------------
  logic       sclk_q;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       chain_q;
  logic [5:0] bit_cnt_q;
  logic       dout_q;

  assign sclk_rise = link.serial_shift_clock && !sclk_q;
  assign sclk_fall = !link.serial_shift_clock && sclk_q;

  // Loads both results at the first ready fall of a sequence, side A first, each MSB first.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_q    <= 1'b0;
      chain_q   <= 1'b1;
      frame_q   <= 40'h0;
      bit_cnt_q <= 6'h0;
      dout_q    <= 1'b0;
    end else begin
      sclk_q <= link.serial_shift_clock;
      if (fire) begin
        frame_q <= {code_a, code_b};                       // see RULE11 see RULE23
      end
      if (xmit_fall) begin
        dout_q    <= frame_q[39];                          // see RULE12 see RULE18
        bit_cnt_q <= 6'h0;
      end else if (!link.transmit_enable_n) begin
        if (sclk_rise) begin
          chain_q <= link.chain_in;                        // see RULE17
        end
        if (sclk_fall) begin
          frame_q <= {frame_q[38:0], chain_q};             // see RULE16 see RULE24
          dout_q  <= frame_q[38];                          // see RULE18
          if (bit_cnt_q != 6'(`CART_FRAME_BITS)) begin
            bit_cnt_q <= bit_cnt_q + 6'h1;                 // see RULE22
          end
        end
      end
    end
  end

  assign link.serial_out    = dout_q;
  assign link.serial_out_oe = !link.transmit_enable_n;     // see RULE20
endmodule // cart_device

/* File: cart_host.sv */
// Readout controller end: polls ready, clocks out frames, holds back shift clock rises near toggles.
module cart_host
  import cart_pkg::*;
(
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst,
  // Link to converter
  cart_link_if.host   link,
  // User side
  input  wire logic   side_select_in,
  input  wire logic   [7:0] chain_length,
  output logic        [39:0] word_data,
  output logic        word_valid,
  output logic        busy
);
  `include "cart_regs.svh"
  cart_ctl_state_t state_q;
  logic [8:0]  quiet_q;
  logic [2:0]  half_q;
  logic [13:0] bits_q;
  logic [39:0] shift_q;
  logic [5:0]  wcnt_q;
  logic        sel_q;
  logic        sclk_q;
  logic        xmit_n_q;

  // Side select follows the user on master clock edges; quiet window restarts.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_q   <= 1'b0;
      quiet_q <= 9'h0;
    end else begin
      sel_q <= side_select_in;                              // see RULE2
      if (side_select_in != sel_q) begin
        quiet_q <= 9'(`CART_QUIET_CYCLES);                  // see RULE13
      end else if (quiet_q != 9'h0) begin
        quiet_q <= quiet_q - 9'h1;
      end
    end
  end

  // Polls ready, drops enable, then generates 40 clocks per chained device.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q    <= CART_C_IDLE;
      xmit_n_q   <= 1'b1;
      sclk_q     <= 1'b0;
      half_q     <= 3'h0;
      bits_q     <= 14'h0;
      shift_q    <= 40'h0;
      wcnt_q     <= 6'h0;
      word_data  <= 40'h0;
      word_valid <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      case (state_q)
        CART_C_IDLE: begin
          if (!link.result_ready_n && quiet_q == 9'h0) begin  // see RULE10 see RULE21
            xmit_n_q <= 1'b0;
            bits_q   <= 14'(chain_length) * 14'(`CART_FRAME_BITS);  // see RULE22
            wcnt_q   <= 6'h0;
            half_q   <= 3'h0;
            state_q  <= CART_C_WAIT;
          end
        end
        CART_C_WAIT: begin
          if (half_q == 3'(`CART_SHIFT_HALF)) begin
            half_q  <= 3'h0;
            state_q <= (bits_q == 14'h0) ? CART_C_DONE : CART_C_HIGH;
          end else begin
            half_q <= half_q + 3'h1;
          end
        end
        CART_C_HIGH: begin
          if (quiet_q != 9'h0) begin
            half_q <= 3'h0;                                 // see RULE13
          end else if (half_q == 3'(`CART_SHIFT_HALF)) begin
            sclk_q  <= 1'b1;
            shift_q <= {shift_q[38:0], link.serial_out};
            half_q  <= 3'h0;
            state_q <= CART_C_LOW;
          end else begin
            half_q <= half_q + 3'h1;
          end
        end
        CART_C_LOW: begin
          if (half_q == 3'(`CART_SHIFT_HALF)) begin
            sclk_q <= 1'b0;
            half_q <= 3'h0;
            bits_q <= bits_q - 14'h1;
            if (wcnt_q == 6'(`CART_FRAME_BITS - 1)) begin
              wcnt_q     <= 6'h0;
              word_data  <= shift_q;
              word_valid <= 1'b1;
            end else begin
              wcnt_q <= wcnt_q + 6'h1;
            end
            state_q <= (bits_q == 14'h1) ? CART_C_DONE : CART_C_HIGH;
          end else begin
            half_q <= half_q + 3'h1;
          end
        end
        CART_C_DONE: begin
          xmit_n_q <= 1'b1;
          state_q  <= CART_C_IDLE;
        end
        default: begin
          state_q <= CART_C_IDLE;
        end
      endcase
    end
  end

  assign link.integration_side_select = sel_q;
  assign link.transmit_enable_n       = xmit_n_q;
  assign link.serial_shift_clock      = sclk_q;
  assign busy                         = state_q != CART_C_IDLE;
endmodule // cart_host

/* File: cart_link_chk.sv */
// Concurrent checks on the link between the converter end and the controller end.
module cart_link_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link signals
  input wire logic integration_side_select,
  input wire logic result_ready_n,
  input wire logic transmit_enable_n,
  input wire logic serial_shift_clock,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic chain_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // Helper counters
  // --------------------------------------------------------------------------
  logic [12:0] since_tog_q;
  logic [7:0]  high_cnt_q;
  logic [9:0]  rise_cnt_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Cycles since the side select last moved, saturating so reset never looks recent.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      since_tog_q <= 13'h1fff;
    end else if ($changed(integration_side_select)) begin
      since_tog_q <= 13'h0000;
    end else if (since_tog_q != 13'h1fff) begin
      since_tog_q <= since_tog_q + 13'h0001;
    end
  end

  // Cycles the transmit enable has been high, saturating.
  always_ff @(posedge core_clk) begin
    if (rst || !transmit_enable_n) begin
      high_cnt_q <= 8'h00;
    end else if (high_cnt_q != 8'hff) begin
      high_cnt_q <= high_cnt_q + 8'h01;
    end
  end

  // Shift clock rises within one transmit window.
  always_ff @(posedge core_clk) begin
    if (rst || $fell(transmit_enable_n)) begin
      rise_cnt_q <= 10'h000;
    end else if ($rose(serial_shift_clock)) begin
      rise_cnt_q <= rise_cnt_q + 10'h001;
    end
  end
  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_oe_tracks_enable: assert property (serial_out_oe == !transmit_enable_n)
    else $error("output enable does not follow transmit enable");
  a_ready_clears_xmit: assert property ($fell(transmit_enable_n) |=> result_ready_n)
    else $error("ready flag not raised after transmit enable fell");
  a_ready_holds_low: assert property (!result_ready_n && transmit_enable_n |=> !result_ready_n)
    else $error("ready flag left low state before transmit");
  a_ready_after_toggle: assert property ($fell(result_ready_n) |-> since_tog_q >= 13'h00ea)
    else $error("ready flag fell too soon after side select toggle");
  a_xmit_idle_before: assert property ($fell(result_ready_n) |-> high_cnt_q >= 8'h64)
    else $error("transmit enable not high long enough before ready");
  a_shift_on_fall:
    assert property ($changed(serial_out) && !transmit_enable_n && !$past(transmit_enable_n, 2)
      |-> $past(serial_shift_clock, 2) && !$past(serial_shift_clock)) else $error("out moved without clock fall");
  a_out_frozen_idle:
    assert property (transmit_enable_n && $past(transmit_enable_n) && $past(transmit_enable_n, 2)
      |-> $stable(serial_out)) else $error("serial output moved while released");
  a_quiet_toggle: assert property (since_tog_q < 13'h01f4 |-> $stable(serial_shift_clock))
    else $error("shift clock active near side select toggle");
  a_frame_bits:
    assert property ($rose(transmit_enable_n) |-> rise_cnt_q != 10'h000 && rise_cnt_q % 10'h028 == 10'h000)
      else $error("frame length not a multiple of forty bits");
  // Main scenarios reached.
  c_ready: cover property ($fell(result_ready_n));
  c_frame_end: cover property ($rose(transmit_enable_n));
  c_toggle: cover property ($changed(integration_side_select));
endmodule // cart_link_chk

/* File: charge_adc_readout_timing_test.sv */
// Self-checking test of the converter and controller ends joined by their link.
module charge_adc_readout_timing_test import cart_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // Signals and design
  // --------------------------------------------------------------------------
  logic         core_clk;
  logic         rst;
  logic         side_select_in;
  logic [7:0]   chain_length;
  cart_result_t result_a;
  cart_result_t result_b;
  logic         result_in_range_low;
  logic         gapped_mode;
  logic         slow_running;
  logic [39:0]  word_data;
  logic         word_valid;
  logic         busy;
  logic [39:0]  words [$];
  int           n_mismatch;
  int           checks;
  int           cycles;
  cart_result_t code_a [4] = '{20'hfffff, 20'h01000, 20'h01001, 20'h12345};
  cart_result_t code_b [4] = '{20'hffffe, 20'h00000, 20'h01000, 20'habcde};
  logic         low_in [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

  cart_link_if link ();

  cart_device cart_device_i (.core_clk(core_clk), .rst(rst), .link(link.device),
    .result_a(result_a), .result_b(result_b), .result_in_range_low(result_in_range_low),
    .gapped_mode(gapped_mode), .slow_running(slow_running));
  cart_host cart_host_i (.core_clk(core_clk), .rst(rst), .link(link.host),
    .side_select_in(side_select_in), .chain_length(chain_length), .word_data(word_data),
    .word_valid(word_valid), .busy(busy));
  cart_link_chk cart_link_chk_i (.core_clk(core_clk), .rst(rst),
    .integration_side_select(link.integration_side_select), .result_ready_n(link.result_ready_n),
    .transmit_enable_n(link.transmit_enable_n), .serial_shift_clock(link.serial_shift_clock),
    .serial_out(link.serial_out), .serial_out_oe(link.serial_out_oe), .chain_in(link.chain_in));

  // Free-running master clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Collects every word the controller delivers and cuts a hang short.
  always @(posedge core_clk) begin
    if (word_valid === 1'b1) begin
      words.push_back(word_data);
    end
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      final_report();
    end
  end
  // --------------------------------------------------------------------------
  // Tasks and sequence
  // --------------------------------------------------------------------------
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  // Moves the side select, then lets the integration run for len clocks.
  task automatic integrate(input int len);
    side_select_in <= ~side_select_in;
    repeat (len) @(posedge core_clk);
  endtask

  task automatic final_report();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Long integrations over a code table, then short ones; the first of each run keeps the previous mode.
  initial begin
    rst = 1'b1;
    side_select_in = 1'b0;
    chain_length = 8'h02;
    result_a = 20'h00000;
    result_b = 20'h00000;
    result_in_range_low = 1'b0;
    link.chain_in = 1'b1;
    n_mismatch = 0;
    checks = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check(link.result_ready_n, 1'b1);
    check(link.serial_out_oe, 1'b0);
    for (int i = 0; i < 4; i++) begin
      result_a <= code_a[i];
      result_b <= code_b[i];
      result_in_range_low <= low_in[i];
      words.delete();
      integrate(5000);
      check(words.size(), 40'h2);
      check(words[0], low_in[i] ? 40'h0 : {code_a[i], code_b[i]});
      check(words[1], 40'hffffffffff);
      // The first integration after reset counts as short, so its slow clock keeps running.
      check(slow_running, i == 0);
      check(busy, 1'b0);
      check(link.result_ready_n, 1'b1);
      check(link.serial_out_oe, 1'b0);
    end
    check(gapped_mode, 1'b0);
    result_a <= 20'h0f0f0;
    result_b <= 20'h10101;
    result_in_range_low <= 1'b0;
    link.chain_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      words.delete();
      integrate(1998);
      // The first short integration still follows a long one, so its clock stops.
      check(slow_running, i != 0);
    end
    check(gapped_mode, 1'b1);
    check(words[0], {20'h0f0f0, 20'h10101});
    check(words[1], 40'h0);
    final_report();
  end
endmodule // charge_adc_readout_timing_test
